// ---- logic/scg_clk_gate.sv ----
/*
  Glitch-free latch-based clock gate for one peripheral clock.
  Assumes the enable comes from flip-flops on the same clock.
*/
`timescale 1ns/100ps
module scg_clk_gate (
  input wire logic clk_in,
  input wire logic en,
  output logic clk_out
);
  logic en_lat;
  always_latch begin
    if (!clk_in) begin
      en_lat = en;
    end
  end
  assign clk_out = clk_in & en_lat;
endmodule : scg_clk_gate

// ---- logic/scg_fault_check.sv ----
/*
  Answers each peripheral access with a fault when its unit is unclocked.
  Assumes access requests come from logic on the same clock.
*/
`timescale 1ns/100ps
module scg_fault_check (
  scg_gate_if.chk gif
);
  import scg_pkg::*;
  // Fault when target unit is gated off or out of range
  always_comb begin
    if (!gif.acc_valid) begin
      gif.acc_fault = 1'b0;
    end else if (gif.acc_unit >= UNIT_SEL_W'(NUM_UNITS)) begin
      gif.acc_fault = 1'b1;
    end else begin
      gif.acc_fault = !gif.unit_en[gif.acc_unit];
    end
  end
endmodule : scg_fault_check

// ---- logic/scg_gate_if.sv ----
/*
  Interface carrying gated-unit enables and fault checks between modules.
  Assumes one clock domain.
*/
`timescale 1ns/100ps
interface scg_gate_if;
  logic [scg_pkg::NUM_UNITS-1:0] unit_en;
  logic acc_valid;
  logic [scg_pkg::UNIT_SEL_W-1:0] acc_unit;
  logic acc_fault;
  modport ctrl (output unit_en, output acc_valid, output acc_unit, input acc_fault);
  modport chk (input unit_en, input acc_valid, input acc_unit, output acc_fault);
endinterface : scg_gate_if

// ---- logic/scg_pkg.sv ----
/*
  Package for the sleep-mode clock gating block: offsets, bit positions,
  reset values and the mode enumeration.
  Assumes a single 25 MHz system clock and a plain register port.
*/
package scg_pkg;
  localparam int unsigned NUM_UNITS = 9;
  localparam logic [31:0] SCG_BASE = 32'h400f_e000;
  localparam logic [11:0] SLEEP_GATE_OFF = 12'h114;
  localparam logic [11:0] INT_STATUS_OFF = 12'h200;
  localparam logic [11:0] INT_MASK_OFF = 12'h204;
  localparam logic [11:0] MODE_STATUS_OFF = 12'h208;
  localparam logic [31:0] SLEEP_GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] SLEEP_GATE_RW_MASK = 32'h0707_1013;
  localparam logic [1:0] INT_RESET = 2'h0;
  localparam int unsigned INT_FAULT_BIT = 0;
  localparam int unsigned INT_WRITE_BIT = 1;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned UNIT_SEL_W = 4;
  typedef logic [4:0] scg_pos_t;
  // Register bit position of each unit, indexed by unit number
  localparam scg_pos_t UNIT_BIT [NUM_UNITS] = '{
    5'h00, 5'h01, 5'h04, 5'h0c, 5'h10, 5'h11, 5'h12, 5'h18, 5'h19};
  typedef enum logic [1:0] {SCG_RUN, SCG_SLEEP, SCG_DEEP} scg_mode_t;
endpackage : scg_pkg

// ---- logic/scg_sleep_gate.sv ----
/*
  Sleep-mode clock gating control: register, enable selection, per-unit
  clock gates, bus fault answers and interrupt.
  Assumes run and deep-sleep enables and the auto gating select come
  from the system controller on the same clock.
*/
// Local design decision: strobed register access.
`timescale 1ns/100ps
module scg_sleep_gate (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [scg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire scg_pkg::scg_mode_t power_mode,
  input wire logic auto_clock_gating_select,
  input wire logic [31:0] run_clock_gate_1,
  input wire logic [31:0] deep_sleep_clock_gate_1,
  input wire logic periph_acc_valid,
  input wire logic [scg_pkg::UNIT_SEL_W-1:0] periph_acc_unit,
  output logic periph_bus_fault,
  output logic [scg_pkg::NUM_UNITS-1:0] unit_clk_en,
  output logic [scg_pkg::NUM_UNITS-1:0] unit_clk,
  output logic irq
);
  import scg_pkg::*;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [31:0] sleep_gate_reg, sleep_gate_next;
  logic [1:0] int_status_reg, int_status_next;
  logic [1:0] int_mask_reg, int_mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [NUM_UNITS-1:0] en_reg, en_next;
  logic [31:0] active_gate;
  logic sel_gate, sel_stat, sel_mask, sel_mode;
  logic [1:0] ev;

  assign sel_gate = (reg_addr == SLEEP_GATE_OFF);
  assign sel_stat = (reg_addr == INT_STATUS_OFF);
  assign sel_mask = (reg_addr == INT_MASK_OFF);
  assign sel_mode = (reg_addr == MODE_STATUS_OFF);

  scg_gate_if gif ();

  always_comb begin
    ev = 2'h0;
    ev[INT_FAULT_BIT] = gif.acc_fault;
    ev[INT_WRITE_BIT] = reg_wr && sel_gate;
    sleep_gate_next = sleep_gate_reg;
    int_mask_next = int_mask_reg;
    int_status_next = int_status_reg;
    if (reg_wr && sel_gate) begin
      sleep_gate_next = reg_wdata & SLEEP_GATE_RW_MASK;
    end
    if (reg_wr && sel_mask) begin
      int_mask_next = reg_wdata[1:0];
    end
    if (reg_wr && sel_stat) begin
      int_status_next = int_status_reg & ~reg_wdata[1:0];
    end
    int_status_next = int_status_next | ev;
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      if (sel_gate) begin
        rdata_next = sleep_gate_reg;
      end else if (sel_stat) begin
        rdata_next = {30'h0, int_status_reg};
      end else if (sel_mask) begin
        rdata_next = {30'h0, int_mask_reg};
      end else if (sel_mode) begin
        rdata_next = {23'h0, en_reg};
      end
    end
  end

  // ************************************************************
  // Enable selection by power mode
  // ************************************************************
  always_comb begin
    active_gate = run_clock_gate_1;
    if (auto_clock_gating_select) begin
      unique case (power_mode)
        SCG_RUN: active_gate = run_clock_gate_1;
        SCG_SLEEP: active_gate = sleep_gate_reg;
        SCG_DEEP: active_gate = deep_sleep_clock_gate_1;
        default: active_gate = run_clock_gate_1;
      endcase
    end
  end

  for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
    assign en_next[i] = active_gate[UNIT_BIT[i]];
    scg_clk_gate u_gate (
      .clk_in(ref_clk),
      .en(en_reg[i]),
      .clk_out(unit_clk[i])
    );
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_gate_reg <= SLEEP_GATE_RESET;
      int_status_reg <= INT_RESET;
      int_mask_reg <= INT_RESET;
      rdata_reg <= 32'h0000_0000;
      en_reg <= '0;
    end else begin
      sleep_gate_reg <= sleep_gate_next;
      int_status_reg <= int_status_next;
      int_mask_reg <= int_mask_next;
      rdata_reg <= rdata_next;
      en_reg <= en_next;
    end
  end

  // ************************************************************
  // Fault checking and outputs
  // ************************************************************
  assign gif.unit_en = en_reg;
  assign gif.acc_valid = periph_acc_valid;
  assign gif.acc_unit = periph_acc_unit;

  scg_fault_check u_fault (
    .gif(gif.chk)
  );

  assign periph_bus_fault = gif.acc_fault;
  assign unit_clk_en = en_reg;
  assign reg_rdata = rdata_reg;
  assign irq = |(int_status_reg & int_mask_reg);

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_RESERVED_ZERO: assert property (
    (sleep_gate_reg & ~SLEEP_GATE_RW_MASK) == 32'h0)
    else $error("reserved gate bits nonzero");
  AST_WRITE_STORES: assert property (
    reg_wr && sel_gate |=> sleep_gate_reg == ($past(reg_wdata) & SLEEP_GATE_RW_MASK))
    else $error("gate write not stored");
  AST_SLEEP_APPLIES: assert property (
    auto_clock_gating_select && power_mode == SCG_SLEEP && !(reg_wr && sel_gate)
    |=> en_reg[3] == sleep_gate_reg[12] && en_reg[2] == sleep_gate_reg[4])
    else $error("sleep enables not applied");
  AST_NO_AUTO_RUN: assert property (
    !auto_clock_gating_select |=> en_reg[0] == $past(run_clock_gate_1[0])
      && en_reg[8] == $past(run_clock_gate_1[25]))
    else $error("run enables not applied");
  AST_FAULT_GATED: assert property (
    periph_acc_valid && periph_acc_unit == 4'h4 && !en_reg[4] |-> periph_bus_fault)
    else $error("missing bus fault");
  AST_NO_FAULT_OPEN: assert property (
    periph_acc_valid && periph_acc_unit == 4'h7 && en_reg[7] |-> !periph_bus_fault)
    else $error("spurious bus fault");
  AST_READ_BACK: assert property (
    reg_rd && sel_gate && !reg_wr |=> reg_rdata == $past(sleep_gate_reg))
    else $error("read data wrong");
  AST_COMP_BITS: assert property (
    auto_clock_gating_select && power_mode == SCG_SLEEP ##1
    auto_clock_gating_select && power_mode == SCG_SLEEP && $stable(sleep_gate_reg)
    |-> en_reg[7] == sleep_gate_reg[24])
    else $error("comparator enable mismatch");
  AST_FAULT_IRQ: assert property (
    periph_bus_fault && int_mask_reg[0] |=> irq [*2] or (irq ##1 !irq))
    else $error("fault interrupt missing");

  COV_SLEEP_WRITE: cover property (reg_wr && sel_gate ##1 power_mode == SCG_SLEEP);
  COV_FAULT: cover property (periph_bus_fault);
  COV_IRQ: cover property (irq);
  COV_DEEP: cover property (auto_clock_gating_select && power_mode == SCG_DEEP);
endmodule : scg_sleep_gate

// ---- sim/scg_periph_model.sv ----
/*
  Model of a bus master reaching the gated peripheral units.
  Assumes the fault answer is combinational in the access cycle.
*/
`timescale 1ns/100ps
module scg_periph_model (
  input wire logic ref_clk,
  output logic acc_valid,
  output logic [scg_pkg::UNIT_SEL_W-1:0] acc_unit,
  input wire logic acc_fault
);
  import scg_pkg::*;
  initial begin
    acc_valid = 1'b0;
    acc_unit = '0;
  end
  // One-cycle access, fault sampled in that cycle
  task access(input int u, output logic f);
    @(posedge ref_clk);
    acc_valid <= 1'b1;
    acc_unit <= u[3:0];
    #1 f = acc_fault;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    acc_unit <= ~acc_unit;
  endtask : access
endmodule : scg_periph_model

// ---- sim/scg_sleep_gate_tb.sv ----
/*
  Self-checking bench for the sleep-mode clock gating block.
  Assumes the peripheral model drives the access port.
*/
`timescale 1ns/100ps
module scg_sleep_gate_tb;
  import scg_pkg::*;
  logic ref_clk, rstn, reg_wr, reg_rd, auto_sel, acc_valid, fault, irq, f;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, run_g, deep_g, v, s, d;
  logic [3:0] acc_unit;
  logic [8:0] en, uclk, e9;
  scg_mode_t mode;
  int bad_count, checks_done, seed;
  scg_sleep_gate dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .power_mode(mode), .auto_clock_gating_select(auto_sel), .run_clock_gate_1(run_g),
    .deep_sleep_clock_gate_1(deep_g), .periph_acc_valid(acc_valid),
    .periph_acc_unit(acc_unit), .periph_bus_fault(fault), .unit_clk_en(en),
    .unit_clk(uclk), .irq(irq));
  scg_periph_model part_u (.ref_clk(ref_clk), .acc_valid(acc_valid), .acc_unit(acc_unit),
    .acc_fault(fault));
  // ****************
  // Helpers
  // ****************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] dat);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] dat);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 dat = reg_rdata;
  endtask : rd
  function automatic logic [8:0] exp_en(int m, bit a, logic [31:0] sl, rn, dp);
    logic [31:0] src;
    logic [8:0] e;
    src = !a ? rn : (m == 1) ? sl : (m == 2) ? dp : rn;
    for (int i = 0; i < 9; i++) e[i] = src[UNIT_BIT[i]];
    return e;
  endfunction : exp_en
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  // ****************
  // Stimulus
  // ****************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    end_of_test;
  end
  initial begin
    seed = 32'hb6a8;
    {rstn, reg_wr, reg_rd, auto_sel, reg_addr, reg_wdata, run_g, deep_g} = '0;
    mode = SCG_RUN;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(12'h114, v);
    chk(v, 32'h0);
    chk(en, 9'h0);
    for (int k = 0; k < 6; k++) begin
      d = $random(seed);
      wr(12'h114, d);
      rd(12'h114, v);
      chk(v, d & 32'h0707_1013);
    end
    s = d & 32'h0707_1013;
    rd(12'h118, v);
    chk(v, 32'h0);
    $display("register test done");
    @(posedge ref_clk);
    run_g <= $random(seed);
    deep_g <= $random(seed);
    for (int m = 0; m < 3; m++) begin
      for (int a = 0; a < 2; a++) begin
        @(posedge ref_clk);
        mode <= scg_mode_t'(m);
        auto_sel <= a[0];
        repeat (3) @(posedge ref_clk);
        #1 chk(en, exp_en(m, a[0], s, run_g, deep_g));
        chk(uclk, exp_en(m, a[0], s, run_g, deep_g));
      end
    end
    $display("mode test done");
    @(posedge ref_clk);
    mode <= SCG_SLEEP;
    repeat (3) @(posedge ref_clk);
    e9 = exp_en(1, 1'b1, s, run_g, deep_g);
    for (int u = 0; u < 10; u++) begin
      part_u.access(u, f);
      chk(f, (u > 8) ? 1'b1 : !e9[u]);
    end
    rd(MODE_STATUS_OFF, v);
    chk(v, {23'h0, e9});
    $display("fault test done");
    #1 chk(irq, 1'b0);
    wr(INT_MASK_OFF, 32'h1);
    #1 chk(irq, 1'b1);
    wr(INT_STATUS_OFF, 32'h3);
    rd(INT_STATUS_OFF, v);
    chk(v, 32'h0);
    chk(irq, 1'b0);
    $display("interrupt test done");
    end_of_test;
  end
endmodule : scg_sleep_gate_tb
